// File: src/adcr_pkg.sv
// Purpose: constants and types for the converter control and result registers
// Assumes: APB slave, 32-bit data, byte registers in the low bits of each word
// Notes:   all register reset values are zero
//
// Summary of operation
// - a 12-bit conversion result is presented across two 8-bit read-only result bytes.
// - with justify 0 the high byte holds bits 11..4 and the low byte bits 3..0 in its top nibble.
// - with justify 1 the high byte holds bits 11..8 in its low nibble; unused bits read zero.
// - the result bytes keep their contents while the converter is disabled.
// - writing the start bit from 0 to 1 resets the converter and clears the busy flag.
// - writing the start bit from 1 to 0 with the enable bit at 1 begins a conversion and sets the busy flag.
// - the busy flag is read-only and reads 1 only while a conversion runs.
// - the converter enable bit disables the converter at 0 and enables it at 1.
// - the 2-bit channel field routes analog input pin 0 to 3 to the converter.
// - internal select 000 picks the external channel and 101 to 111 pick the amplifier output.
// - when an external and an internal signal are both chosen only the internal one converts.
// - when external and bandgap reference are both chosen only the bandgap is used.
// - a pin set as analog input loses its digital function and its pull-high.
// - the clock rate field divides the system clock by 1 to 128 for codes 000 to 111.
// - internal codes 001-011 and 101-111 add supply or amplifier fractions; others act as 000.
package adcr_pkg;
   // =========================================================
   // register offsets
   localparam logic [7:0] OFS_RESULT_LOW   = 8'h00;
   localparam logic [7:0] OFS_RESULT_HIGH  = 8'h04;
   localparam logic [7:0] OFS_MAIN_CONTROL = 8'h08;
   localparam logic [7:0] OFS_INPUT_CLOCK  = 8'h0c;
   localparam logic [7:0] OFS_REF_AMP      = 8'h10;
   localparam logic [7:0] OFS_PORT_FUNC    = 8'h14;
   // =========================================================
   // reset values
   localparam logic [7:0] RST_MAIN_CONTROL = 8'h00;
   localparam logic [7:0] RST_INPUT_CLOCK  = 8'h00;
   localparam logic [7:0] RST_REF_AMP      = 8'h00;
   localparam logic [7:0] RST_PORT_FUNC    = 8'h00;
   // =========================================================
   // field positions
   localparam int MC_START_BIT   = 7;
   localparam int MC_BUSY_BIT    = 6;
   localparam int MC_ENABLE_BIT  = 5;
   localparam int MC_JUSTIFY_BIT = 4;
   localparam int MC_CHAN_LSB    = 0;
   localparam int ICS_SIG_LSB    = 5;
   localparam int ICS_RATE_LSB   = 0;
   localparam int RAC_AMP_BIT    = 7;
   localparam int RAC_BG_BIT     = 6;
   localparam int RAC_REF_LSB    = 0;
   localparam int REF_VREF_BIT   = 0;
   localparam int REF_BG_BIT     = 1;
   // =========================================================
   // widths and codes
   localparam int RESULT_W  = 12;
   localparam int DIV_CNT_W = 7;
   localparam logic [1:0] REF_SRC_SUPPLY  = 2'h0;
   localparam logic [1:0] REF_SRC_PIN     = 2'h1;
   localparam logic [1:0] REF_SRC_BANDGAP = 2'h2;
   localparam logic [2:0] SIG_EXTERNAL    = 3'h0;
   localparam logic [2:0] SIG_UNUSED      = 3'h4;
   typedef enum logic {ST_IDLE, ST_BUSY} adcr_state_t;
endpackage : adcr_pkg

// File: src/adcr_clk_div.sv
// Purpose: conversion clock tick from the system clock
// Assumes: tick is one cycle wide, every 2^rate cycles
// Notes:   counter restarts while disabled
`timescale 1ns/1ns
module adcr_clk_div (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_reset_n,
   // control
   input  wire logic       i_enable,
   input  wire logic [2:0] i_rate,
   // tick
   output logic            o_tick
);
   typedef struct packed {
      logic [adcr_pkg::DIV_CNT_W-1:0] cnt;
      logic                           tick;
   } adcr_div_t;

   adcr_div_t                      s;
   adcr_div_t                      next_s;
   logic [adcr_pkg::DIV_CNT_W-1:0] limit;

   // =========================================================
   // divider
   always_comb begin
      limit = adcr_pkg::DIV_CNT_W'((8'h01 << i_rate) - 8'h01);
      next_s = s;
      if (!i_enable) begin
         next_s.cnt  = '0;
         next_s.tick = 1'b0;
      end else if (s.cnt >= limit) begin
         next_s.cnt  = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.cnt  = adcr_pkg::DIV_CNT_W'(s.cnt + 7'h01);
         next_s.tick = 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign o_tick = s.tick;

   chk_div_gap: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_tick && i_rate == 3'h1 && $stable(i_rate) && i_enable ##1 i_enable
      |-> !o_tick) else $error("divide by two ticked twice in a row");
endmodule : adcr_clk_div

// File: src/adcr_input_mux.sv
// Purpose: resolves input signal and reference choices for the analog core
// Assumes: selections come from software registers
// Notes:   outputs are registered
`timescale 1ns/1ns
module adcr_input_mux (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_reset_n,
   // selections
   input  wire logic [2:0] i_sig_sel,
   input  wire logic [1:0] i_chan,
   input  wire logic [3:0] i_ref_sel,
   // resolved routing
   output logic            o_use_internal,
   output logic [2:0]      o_internal_sel,
   output logic [1:0]      o_ext_channel,
   output logic [1:0]      o_ref_src
);
   typedef struct packed {
      logic       use_int;
      logic [2:0] int_sel;
      logic [1:0] chan;
      logic [1:0] ref_src;
   } adcr_mux_t;

   adcr_mux_t s;
   adcr_mux_t next_s;

   // =========================================================
   // routing
   always_comb begin
      next_s      = s;
      next_s.chan = i_chan;
      if (i_sig_sel == adcr_pkg::SIG_EXTERNAL || i_sig_sel == adcr_pkg::SIG_UNUSED) begin
         next_s.use_int = 1'b0;
         next_s.int_sel = adcr_pkg::SIG_EXTERNAL;
      end else begin
         next_s.use_int = 1'b1;
         next_s.int_sel = i_sig_sel;
      end
      if (i_ref_sel[adcr_pkg::REF_BG_BIT]) begin
         next_s.ref_src = adcr_pkg::REF_SRC_BANDGAP;
      end else if (i_ref_sel[adcr_pkg::REF_VREF_BIT]) begin
         next_s.ref_src = adcr_pkg::REF_SRC_PIN;
      end else begin
         next_s.ref_src = adcr_pkg::REF_SRC_SUPPLY;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign o_use_internal = s.use_int;
   assign o_internal_sel = s.int_sel;
   assign o_ext_channel  = s.chan;
   assign o_ref_src      = s.ref_src;

   chk_internal_wins: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_sig_sel[2:0] inside {3'h5, 3'h6, 3'h7} |=> o_use_internal && o_internal_sel == $past(i_sig_sel))
      else $error("amplifier code did not select internal signal");
   chk_bandgap_wins: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_ref_sel[adcr_pkg::REF_BG_BIT] |=> o_ref_src == adcr_pkg::REF_SRC_BANDGAP)
      else $error("bandgap reference not preferred");
endmodule : adcr_input_mux

// File: src/adcr_ctrl.sv
// Purpose: converter control, result registers and APB slave
// Assumes: core pulses i_core_done for one cycle with i_core_result valid
// Notes:   APB answers one cycle after the access phase begins
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ns
module adcr_ctrl (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   // apb slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // converter core
   input  wire logic        i_core_done,
   input  wire logic [11:0] i_core_result,
   output logic             o_core_reset,
   output logic             o_core_start,
   output logic             o_conv_tick,
   output logic             o_converter_enable,
   // analog routing
   output logic             o_use_internal,
   output logic [2:0]       o_internal_sel,
   output logic [1:0]       o_ext_channel,
   output logic [1:0]       o_ref_src,
   output logic             o_amp_enable,
   output logic             o_bandgap_buffer_enable,
   // analog pins
   input  wire logic [3:0]  i_pullup_req,
   output logic [3:0]       o_pin_analog,
   output logic [3:0]       o_pullup_en
);
   typedef struct packed {
      logic                   mc_start;
      logic                   mc_enable;
      logic                   mc_justify;
      logic [1:0]             mc_chan;
      logic [2:0]             sig_sel;
      logic [2:0]             clk_rate;
      logic                   amp_en;
      logic                   bg_en;
      logic [3:0]             ref_sel;
      logic [3:0]             port_fn;
      logic                   busy;
      adcr_pkg::adcr_state_t  fsm;
      logic [7:0]             res_lo;
      logic [7:0]             res_hi;
      logic [31:0]            prdata;
      logic                   pready;
      logic                   pslverr;
      logic                   core_reset;
      logic                   core_start;
      logic [3:0]             pin_analog;
      logic [3:0]             pullup_en;
   } adcr_regs_t;

   adcr_regs_t  s;
   adcr_regs_t  next_s;
   logic        setup_done;
   logic        xfer_done;
   logic        wr_main;
   logic        start_rise;
   logic        start_fall;
   logic        done_take;
   logic [7:0]  rd_byte;

   // =========================================================
   // address decode
   function automatic logic is_mapped(input logic [7:0] addr);
      logic hit;
      hit = 1'b0;
      if (addr == adcr_pkg::OFS_RESULT_LOW) begin
         hit = 1'b1;
      end else if (addr == adcr_pkg::OFS_RESULT_HIGH) begin
         hit = 1'b1;
      end else if (addr == adcr_pkg::OFS_MAIN_CONTROL) begin
         hit = 1'b1;
      end else if (addr == adcr_pkg::OFS_INPUT_CLOCK) begin
         hit = 1'b1;
      end else if (addr == adcr_pkg::OFS_REF_AMP) begin
         hit = 1'b1;
      end else if (addr == adcr_pkg::OFS_PORT_FUNC) begin
         hit = 1'b1;
      end
      return hit;
   endfunction : is_mapped

   function automatic logic is_write_to(input logic [7:0] addr, input logic [7:0] ofs,
                                        input logic done, input logic wr);
      return done && wr && addr == ofs;
   endfunction : is_write_to

   // =========================================================
   // read data
   always_comb begin
      rd_byte = 8'h00;
      if (i_paddr == adcr_pkg::OFS_RESULT_LOW) begin
         rd_byte = s.res_lo;
      end else if (i_paddr == adcr_pkg::OFS_RESULT_HIGH) begin
         rd_byte = s.res_hi;
      end else if (i_paddr == adcr_pkg::OFS_MAIN_CONTROL) begin
         rd_byte = {s.mc_start, s.busy, s.mc_enable, s.mc_justify, 2'h0, s.mc_chan};
      end else if (i_paddr == adcr_pkg::OFS_INPUT_CLOCK) begin
         rd_byte = {s.sig_sel, 2'h0, s.clk_rate};
      end else if (i_paddr == adcr_pkg::OFS_REF_AMP) begin
         rd_byte = {s.amp_en, s.bg_en, 2'h0, s.ref_sel};
      end else if (i_paddr == adcr_pkg::OFS_PORT_FUNC) begin
         rd_byte = {4'h0, s.port_fn};
      end
   end

   // =========================================================
   // next state
   always_comb begin
      next_s     = s;
      setup_done = i_psel && i_penable && !s.pready;
      xfer_done  = i_psel && i_penable && s.pready;
      wr_main    = is_write_to(i_paddr, adcr_pkg::OFS_MAIN_CONTROL, xfer_done, i_pwrite);
      start_rise = wr_main && !s.mc_start && i_pwdata[adcr_pkg::MC_START_BIT];
      start_fall = wr_main && s.mc_start && !i_pwdata[adcr_pkg::MC_START_BIT];
      done_take  = s.fsm == adcr_pkg::ST_BUSY && i_core_done && s.mc_enable && !start_rise;

      // bus answer
      next_s.pready  = setup_done;
      next_s.pslverr = setup_done && !is_mapped(i_paddr);
      next_s.prdata  = (setup_done && !i_pwrite) ? {24'h0, rd_byte} : 32'h0;

      // register writes
      if (wr_main) begin
         next_s.mc_start   = i_pwdata[adcr_pkg::MC_START_BIT];
         next_s.mc_enable  = i_pwdata[adcr_pkg::MC_ENABLE_BIT];
         next_s.mc_justify = i_pwdata[adcr_pkg::MC_JUSTIFY_BIT];
         next_s.mc_chan    = i_pwdata[adcr_pkg::MC_CHAN_LSB +: 2];
      end
      if (is_write_to(i_paddr, adcr_pkg::OFS_INPUT_CLOCK, xfer_done, i_pwrite)) begin
         next_s.sig_sel  = i_pwdata[adcr_pkg::ICS_SIG_LSB +: 3];
         next_s.clk_rate = i_pwdata[adcr_pkg::ICS_RATE_LSB +: 3];
      end
      if (is_write_to(i_paddr, adcr_pkg::OFS_REF_AMP, xfer_done, i_pwrite)) begin
         next_s.amp_en  = i_pwdata[adcr_pkg::RAC_AMP_BIT];
         next_s.bg_en   = i_pwdata[adcr_pkg::RAC_BG_BIT];
         next_s.ref_sel = i_pwdata[adcr_pkg::RAC_REF_LSB +: 4];
      end
      if (is_write_to(i_paddr, adcr_pkg::OFS_PORT_FUNC, xfer_done, i_pwrite)) begin
         next_s.port_fn = i_pwdata[3:0];
      end

      // analog pins
      next_s.pin_analog = s.port_fn;
      next_s.pullup_en  = i_pullup_req & ~s.port_fn;

      // conversion sequence
      next_s.core_reset = start_rise;
      next_s.core_start = 1'b0;
      case (s.fsm)
         adcr_pkg::ST_IDLE: begin
            next_s.busy = 1'b0;
         end
         adcr_pkg::ST_BUSY: begin
            if (done_take) begin
               if (s.mc_justify) begin
                  next_s.res_hi = {4'h0, i_core_result[11:8]};
                  next_s.res_lo = i_core_result[7:0];
               end else begin
                  next_s.res_hi = i_core_result[11:4];
                  next_s.res_lo = {i_core_result[3:0], 4'h0};
               end
               next_s.busy = 1'b0;
               next_s.fsm  = adcr_pkg::ST_IDLE;
            end
         end
         default: begin
            next_s.fsm = adcr_pkg::ST_IDLE;
         end
      endcase
      if (start_rise) begin
         next_s.busy = 1'b0;
         next_s.fsm  = adcr_pkg::ST_IDLE;
      end
      if (start_fall && next_s.mc_enable) begin
         next_s.busy       = 1'b1;
         next_s.fsm        = adcr_pkg::ST_BUSY;
         next_s.core_start = 1'b1;
      end
      if (!next_s.mc_enable) begin
         next_s.busy = 1'b0;
         next_s.fsm  = adcr_pkg::ST_IDLE;
      end
   end

   // =========================================================
   // state register
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s            <= '0;
         s.mc_start   <= adcr_pkg::RST_MAIN_CONTROL[adcr_pkg::MC_START_BIT];
         s.mc_enable  <= adcr_pkg::RST_MAIN_CONTROL[adcr_pkg::MC_ENABLE_BIT];
         s.mc_justify <= adcr_pkg::RST_MAIN_CONTROL[adcr_pkg::MC_JUSTIFY_BIT];
         s.mc_chan    <= adcr_pkg::RST_MAIN_CONTROL[1:0];
         s.sig_sel    <= adcr_pkg::RST_INPUT_CLOCK[7:5];
         s.clk_rate   <= adcr_pkg::RST_INPUT_CLOCK[2:0];
         s.amp_en     <= adcr_pkg::RST_REF_AMP[7];
         s.bg_en      <= adcr_pkg::RST_REF_AMP[6];
         s.ref_sel    <= adcr_pkg::RST_REF_AMP[3:0];
         s.port_fn    <= adcr_pkg::RST_PORT_FUNC[3:0];
         s.fsm        <= adcr_pkg::ST_IDLE;
      end else begin
         s <= next_s;
      end
   end

   // =========================================================
   // submodules
   adcr_clk_div u_clk_div (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_enable  (s.mc_enable),
      .i_rate    (s.clk_rate),
      .o_tick    (o_conv_tick)
   );

   adcr_input_mux u_input_mux (
      .i_clk          (i_clk),
      .i_reset_n      (i_reset_n),
      .i_sig_sel      (s.sig_sel),
      .i_chan         (s.mc_chan),
      .i_ref_sel      (s.ref_sel),
      .o_use_internal (o_use_internal),
      .o_internal_sel (o_internal_sel),
      .o_ext_channel  (o_ext_channel),
      .o_ref_src      (o_ref_src)
   );

   // =========================================================
   // outputs
   assign o_prdata                = s.prdata;
   assign o_pready                = s.pready;
   assign o_pslverr               = s.pslverr;
   assign o_core_reset            = s.core_reset;
   assign o_core_start            = s.core_start;
   assign o_converter_enable      = s.mc_enable;
   assign o_amp_enable            = s.amp_en;
   assign o_bandgap_buffer_enable = s.bg_en;
   assign o_pin_analog            = s.pin_analog;
   assign o_pullup_en             = s.pullup_en;

   // =========================================================
   // checks
   chk_start_rise_reset: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      start_rise |=> !s.busy && o_core_reset ##1 !o_core_reset)
      else $error("start rise did not reset converter");

   chk_start_fall_busy: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      start_fall && i_pwdata[adcr_pkg::MC_ENABLE_BIT] |=> s.busy && o_core_start
      ##1 !o_core_start) else $error("start fall did not begin conversion");

   chk_busy_readback: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_pready && $past(i_paddr) == adcr_pkg::OFS_MAIN_CONTROL && !$past(i_pwrite)
      |-> o_prdata[adcr_pkg::MC_BUSY_BIT] == $past(s.busy))
      else $error("busy flag read back wrong");

   chk_justify_left: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      done_take && !s.mc_justify |=> s.res_hi == $past(i_core_result[11:4])
      && s.res_lo == {$past(i_core_result[3:0]), 4'h0})
      else $error("left justified result wrong");

   chk_justify_right: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      done_take && s.mc_justify |=> s.res_hi == {4'h0, $past(i_core_result[11:8])}
      && s.res_lo == $past(i_core_result[7:0]))
      else $error("right justified result wrong");

   chk_hold_disabled: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !s.mc_enable |=> $stable(s.res_lo) && $stable(s.res_hi))
      else $error("result changed while disabled");

   chk_disabled_idle: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !s.mc_enable |-> !s.busy && !o_core_start)
      else $error("busy while converter disabled");

   chk_load_then_idle: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      $fell(s.busy) && !$past(start_rise) && $past(s.mc_enable) && s.mc_enable
      |-> $past(done_take)) else $error("busy cleared without loading result");

   chk_pullup_cut: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      s.port_fn != 4'h0 ##1 $stable(s.port_fn) |-> (o_pullup_en & s.port_fn) == 4'h0
      && o_pin_analog == s.port_fn) else $error("pull-high left on analog pin");

   chk_apb_answer: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready)
      else $error("apb answer not one cycle");
endmodule : adcr_ctrl

// File: sim/adcr_ctrl_tb.sv
// Purpose: self-checking bench for the converter control and result registers
// Assumes: registered apb answer; bench plays the converter core
// Notes:   apb answer taken at the rising edge; level checks at the falling edge
`timescale 1ns/1ns
module adcr_ctrl_tb;
   // ==========================================
   // signals
   logic        i_clk          = 1'b0;
   logic        i_reset_n      = 1'b0;
   logic        i_psel         = 1'b0;
   logic        i_penable      = 1'b0;
   logic        i_pwrite       = 1'b0;
   logic [7:0]  i_paddr        = 8'h00;
   logic [31:0] i_pwdata       = 32'h0;
   logic        i_core_done    = 1'b0;
   logic [11:0] i_core_result  = 12'h000;
   logic [3:0]  i_pullup_req   = 4'h0;
   logic [31:0] o_prdata;
   logic        o_pready, o_pslverr, o_core_reset, o_core_start, o_conv_tick;
   logic        o_converter_enable, o_use_internal, o_amp_enable, o_bandgap_buffer_enable;
   logic [2:0]  o_internal_sel;
   logic [1:0]  o_ext_channel, o_ref_src;
   logic [3:0]  o_pin_analog, o_pullup_en;
   logic [31:0] rd;
   logic        err;
   int          bad_count = 0;
   int          n_compared = 0;
   int          n_rst = 0;
   int          n_start = 0;

   always #2 i_clk = ~i_clk;

   adcr_ctrl dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(i_psel),
      .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
      .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
      .i_core_done(i_core_done), .i_core_result(i_core_result), .o_core_reset(o_core_reset),
      .o_core_start(o_core_start), .o_conv_tick(o_conv_tick),
      .o_converter_enable(o_converter_enable), .o_use_internal(o_use_internal),
      .o_internal_sel(o_internal_sel), .o_ext_channel(o_ext_channel), .o_ref_src(o_ref_src),
      .o_amp_enable(o_amp_enable), .o_bandgap_buffer_enable(o_bandgap_buffer_enable),
      .i_pullup_req(i_pullup_req), .o_pin_analog(o_pin_analog), .o_pullup_en(o_pullup_en));

   // core pulse counters
   always @(posedge i_clk) begin
      if (o_core_reset === 1'b1) n_rst++;
      if (o_core_start === 1'b1) n_start++;
   end

   // ==========================================
   // shared tasks
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk);
      i_penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge i_clk);
         if (o_pready === 1'b1) break;
      end
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      if (k == 20) begin
         bad_count++;
         results();
      end
   endtask : apb

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string name);
      apb(1'b0, a, 32'h0);
      check(name, rd, exp);
   endtask : rdchk

   task automatic settle();
      repeat (3) @(negedge i_clk);
   endtask : settle

   task automatic convert(input logic [7:0] ctl, input logic [11:0] res);
      apb(1'b1, 8'h08, {24'h0, ctl | 8'ha0});
      apb(1'b1, 8'h08, {24'h0, ctl | 8'h20});
      rdchk(8'h08, {24'h0, ctl | 8'h60}, "busy while converting");
      @(posedge i_clk);
      i_core_done <= 1'b1;
      i_core_result <= res;
      @(posedge i_clk);
      i_core_done <= 1'b0;
      i_core_result <= ~res;
      repeat (2) @(posedge i_clk);
   endtask : convert

   // ==========================================
   // scenarios
   task automatic t_regs();
      for (int a = 0; a < 6; a++) rdchk(8'(a * 4), 32'h0, "reset value");
      apb(1'b0, 8'h1c, 32'h0);
      check("unmapped err", 32'(err), 32'h1);
      check("unmapped data", rd, 32'h0);
      apb(1'b1, 8'h04, 32'hff);
      rdchk(8'h04, 32'h0, "result read only");
      apb(1'b1, 8'h08, 32'h7f);
      rdchk(8'h08, 32'h33, "main control");
      apb(1'b1, 8'h0c, 32'hff);
      rdchk(8'h0c, 32'he7, "clock select");
      apb(1'b1, 8'h10, 32'hff);
      rdchk(8'h10, 32'hcf, "ref amp");
      apb(1'b1, 8'h08, 32'h00);
   endtask : t_regs

   task automatic t_convert();
      int r0;
      int s0;
      r0 = n_rst;
      s0 = n_start;
      convert(8'h00, 12'habc);
      check("reset pulses", 32'(n_rst - r0), 32'h1);
      check("start pulses", 32'(n_start - s0), 32'h1);
      rdchk(8'h04, 32'hab, "high left");
      rdchk(8'h00, 32'hc0, "low left");
      rdchk(8'h08, 32'h20, "busy done");
      convert(8'h10, 12'h5a7);
      rdchk(8'h04, 32'h05, "high right");
      rdchk(8'h00, 32'ha7, "low right");
      apb(1'b1, 8'h08, 32'ha0);
      apb(1'b1, 8'h08, 32'h20);
      apb(1'b1, 8'h08, 32'ha0);
      rdchk(8'h08, 32'ha0, "busy cleared");
      apb(1'b1, 8'h08, 32'h10);
      settle();
      check("enable off", 32'(o_converter_enable), 32'h0);
      rdchk(8'h00, 32'ha7, "kept disabled");
      s0 = n_start;
      apb(1'b1, 8'h08, 32'h90);
      apb(1'b1, 8'h08, 32'h10);
      settle();
      check("no start disabled", 32'(n_start - s0), 32'h0);
   endtask : t_convert

   task automatic t_route();
      logic [2:0] e;
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, 8'h08, 32'(c));
         settle();
         check("channel", 32'(o_ext_channel), 32'(c));
      end
      for (int s = 0; s < 8; s++) begin
         apb(1'b1, 8'h0c, 32'(s << 5));
         settle();
         e = (s == 0 || s == 4) ? 3'h0 : 3'(s);
         check("internal sel", 32'(o_internal_sel), 32'(e));
         check("use internal", 32'(o_use_internal), 32'(e != 3'h0));
      end
      for (int r = 0; r < 4; r++) begin
         apb(1'b1, 8'h10, 32'(8'hc0 | r));
         settle();
         check("ref src", 32'(o_ref_src), (r >= 2) ? 32'h2 : 32'(r));
         check("amp bg", 32'({o_amp_enable, o_bandgap_buffer_enable}), 32'h3);
      end
   endtask : t_route

   task automatic t_divider();
      int k;
      apb(1'b1, 8'h08, 32'h20);
      for (int r = 0; r < 8; r++) begin
         apb(1'b1, 8'h0c, 32'(r));
         settle();
         k = 0;
         repeat (256) begin
            @(negedge i_clk);
            if (o_conv_tick === 1'b1) k++;
         end
         check("ticks", 32'(k), 32'(256 >> r));
      end
   endtask : t_divider

   task automatic t_pins();
      apb(1'b1, 8'h14, 32'h5);
      i_pullup_req <= 4'hf;
      settle();
      check("pin analog", 32'(o_pin_analog), 32'h5);
      check("pullup", 32'(o_pullup_en), 32'ha);
   endtask : t_pins

   // ==========================================
   // main sequence
   initial begin
      repeat (16) @(posedge i_clk);
      i_reset_n <= 1'b1;
      t_regs();
      t_convert();
      t_route();
      t_divider();
      t_pins();
      results();
   end
endmodule : adcr_ctrl_tb
